// File: logic/ppom_defs.vh
// constants for the port pin override mux
// How it works
// - set analog bit makes Port 0 pin analog, except the pin carrying clock output
// - analog bit beats Port 0 function select
// - debug mode owns P2.1 data, P2.2 clock
// - no pull on debug pins in debug
// - crystal takes P2.3, P2.4 when select low
// - crystal pins analog while select stays low
// - six observation controls drive radio signals P1[0:5]
// - clock output enable drives slow clock pin
// - clock output overrides chosen Port 0 pin
// - clock output driven in every power mode
// - regulator status enable drives chosen Port 1
// - regulator pin one powered, zero when off
// - latches bit-addressable; XDATA mirrors read-only
// - Port 0 and 1 latches reset ones
// - Port 2 five bits, upper read zero
// - function select zero GPIO, one peripheral
// - direction zero input, one output
`ifndef PPOM_DEFS_VH
`define PPOM_DEFS_VH

// -----------------------------------------------------------------
// register addresses
// -----------------------------------------------------------------
`define PPOM_SFR_PORT_ZERO    8'h80
`define PPOM_SFR_PORT_ONE     8'h90
`define PPOM_SFR_PORT_TWO     8'hA0
`define PPOM_XD_PORT_ZERO     16'h7080
`define PPOM_XD_PORT_ONE      16'h7090
`define PPOM_XD_PORT_TWO      16'h70A0

// -----------------------------------------------------------------
// reset values and widths
// -----------------------------------------------------------------
`define PPOM_RST_PORT_ZERO    8'hFF
`define PPOM_RST_PORT_ONE     8'hFF
`define PPOM_RST_PORT_TWO     5'h1F
`define PPOM_P2_WIDTH         5
`define PPOM_P2_PAD           3'h0
`define PPOM_ZERO_BYTE        8'h00
`define PPOM_ZERO_FIVE        5'h00
`define PPOM_PULL_ALLOWED     5'h1F

// -----------------------------------------------------------------
// pin positions and encodings
// -----------------------------------------------------------------
`define PPOM_DEBUG_DATA_BIT   1
`define PPOM_DEBUG_CLOCK_BIT  2
`define PPOM_XTAL_BIT_A       3
`define PPOM_XTAL_BIT_B       4
`define PPOM_OBS_PINS         6
`define PPOM_OBS_SIG_0        2'h0
`define PPOM_OBS_SIG_1        2'h1
`define PPOM_OBS_SIG_2        2'h2

`endif

// File: logic/ppom_pin_sync.v
// three-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module ppom_pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] pin_raw,
  output wire [WIDTH-1:0] pin_level
);

  genvar i;

  // -----------------------------------------------------------------
  // per-bit chain; level changes once stages two and three agree
  // -----------------------------------------------------------------
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage_one;
      reg stage_two;
      reg stage_three;
      reg level;
      always @(posedge clk) begin
        if (!reset_n) begin
          stage_one   <= 1'b0;
          stage_two   <= 1'b0;
          stage_three <= 1'b0;
          level       <= 1'b0;
        end else begin
          stage_one   <= pin_raw[i];
          stage_two   <= stage_one;
          stage_three <= stage_two;
          if (stage_two == stage_three) begin
            level <= stage_three;
          end
        end
      end
      assign pin_level[i] = level;
    end
  endgenerate

endmodule // ppom_pin_sync

// File: logic/ppom_top.v
// port pin override mux with port latch registers
`timescale 1ns/1ns
`include "ppom_defs.vh"
module ppom_top (
  input  wire        clk,
  input  wire        reset_n,
  // sfr access
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_we,
  input  wire        sfr_re,
  output reg  [7:0]  sfr_rdata,
  input  wire [7:0]  sfr_bit_addr,
  input  wire        sfr_bit_wdata,
  input  wire        sfr_bit_we,
  // xdata mirror access
  input  wire [15:0] xdata_addr,
  input  wire        xdata_re,
  output reg  [7:0]  xdata_rdata,
  // configuration levels
  input  wire [7:0]  analog_input_config,
  input  wire [7:0]  port_zero_function_select,
  input  wire [7:0]  port_one_function_select,
  input  wire [4:0]  port_two_function_select,
  input  wire [7:0]  port_zero_direction,
  input  wire [7:0]  port_one_direction,
  input  wire [4:0]  port_two_direction,
  input  wire        slow_crystal_select,
  input  wire [5:0]  observation_enable,
  input  wire [11:0] observation_select,
  input  wire        clock_output_enable,
  input  wire [2:0]  clock_output_pin_select,
  input  wire        regulator_status_output_enable,
  input  wire [2:0]  regulator_status_pin_select,
  // internal sources
  input  wire        debug_mode,
  input  wire        debug_data_out,
  input  wire        debug_data_oe,
  input  wire        debug_clock_out,
  input  wire        debug_clock_oe,
  input  wire [2:0]  radio_observe_signal,
  input  wire        slow_clock,
  input  wire        regulator_powered,
  input  wire [7:0]  periph_zero_out,
  input  wire [7:0]  periph_zero_oe,
  input  wire [7:0]  periph_one_out,
  input  wire [7:0]  periph_one_oe,
  input  wire [4:0]  periph_two_out,
  input  wire [4:0]  periph_two_oe,
  // pin levels seen by logic
  output wire [7:0]  port_zero_level,
  output wire [7:0]  port_one_level,
  output wire [4:0]  port_two_level,
  // pads
  input  wire [7:0]  port_zero_in,
  output reg  [7:0]  port_zero_out,
  output reg  [7:0]  port_zero_oe,
  output reg  [7:0]  port_zero_analog,
  input  wire [7:0]  port_one_in,
  output reg  [7:0]  port_one_out,
  output reg  [7:0]  port_one_oe,
  input  wire [4:0]  port_two_in,
  output reg  [4:0]  port_two_out,
  output reg  [4:0]  port_two_oe,
  output reg  [4:0]  port_two_analog,
  output reg  [4:0]  port_two_pull_enable
);

  reg  [7:0] port_zero_latch;
  reg  [7:0] port_one_latch;
  reg  [4:0] port_two_latch;
  reg  [7:0] next_sfr_rdata;
  reg  [7:0] next_xdata_rdata;
  wire [7:0] next_zero_out;
  wire [7:0] next_zero_oe;
  wire [7:0] next_zero_analog;
  wire [7:0] next_one_out;
  wire [7:0] next_one_oe;
  wire [4:0] next_two_out;
  wire [4:0] next_two_oe;
  wire [4:0] next_two_analog;
  wire [4:0] next_two_pull;
  wire [7:0] zero_read;
  wire [7:0] one_read;
  wire [4:0] two_read;
  wire [2:0] bit_sel;
  wire [7:0] bit_base;

  genvar i;

  // -----------------------------------------------------------------
  // pin input synchronisers
  // -----------------------------------------------------------------
  ppom_pin_sync #(.WIDTH(21)) u_sync (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_raw   ({port_two_in, port_one_in, port_zero_in}),
    .pin_level ({port_two_level, port_one_level, port_zero_level})
  );

  // -----------------------------------------------------------------
  // port latch registers, byte and bit writes
  // -----------------------------------------------------------------
  assign bit_sel  = sfr_bit_addr[2:0];
  assign bit_base = {sfr_bit_addr[7:3], 3'h0};

  // byte and bit writes; bits above four of port two are not held
  always @(posedge clk) begin
    if (!reset_n) begin
      port_zero_latch <= `PPOM_RST_PORT_ZERO;
      port_one_latch  <= `PPOM_RST_PORT_ONE;
      port_two_latch  <= `PPOM_RST_PORT_TWO;
    end else begin
      if (sfr_we) begin
        case (sfr_addr)
          `PPOM_SFR_PORT_ZERO: port_zero_latch <= sfr_wdata;
          `PPOM_SFR_PORT_ONE:  port_one_latch  <= sfr_wdata;
          `PPOM_SFR_PORT_TWO:
            port_two_latch <= sfr_wdata[`PPOM_P2_WIDTH-1:0];
          default: ;
        endcase
      end
      if (sfr_bit_we) begin
        case (bit_base)
          `PPOM_SFR_PORT_ZERO: port_zero_latch[bit_sel] <= sfr_bit_wdata;
          `PPOM_SFR_PORT_ONE:  port_one_latch[bit_sel]  <= sfr_bit_wdata;
          `PPOM_SFR_PORT_TWO: begin
            if (bit_sel < `PPOM_P2_WIDTH) begin
              port_two_latch[bit_sel] <= sfr_bit_wdata;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // read values: pin level for inputs, latch for outputs
  // -----------------------------------------------------------------
  assign zero_read = (port_zero_direction & port_zero_latch) |
                     (~port_zero_direction & port_zero_level);
  assign one_read  = (port_one_direction & port_one_latch) |
                     (~port_one_direction & port_one_level);
  assign two_read  = (port_two_direction & port_two_latch) |
                     (~port_two_direction & port_two_level);

  // sfr read decode; unmapped addresses return zero
  always @* begin
    next_sfr_rdata = `PPOM_ZERO_BYTE;
    case (sfr_addr)
      `PPOM_SFR_PORT_ZERO: next_sfr_rdata = zero_read;
      `PPOM_SFR_PORT_ONE:  next_sfr_rdata = one_read;
      `PPOM_SFR_PORT_TWO:  next_sfr_rdata = {`PPOM_P2_PAD, two_read};
      default:             next_sfr_rdata = `PPOM_ZERO_BYTE;
    endcase
  end

  // xdata mirror decode; read only, writes have no port at all
  always @* begin
    next_xdata_rdata = `PPOM_ZERO_BYTE;
    case (xdata_addr)
      `PPOM_XD_PORT_ZERO: next_xdata_rdata = port_zero_latch;
      `PPOM_XD_PORT_ONE:  next_xdata_rdata = port_one_latch;
      `PPOM_XD_PORT_TWO:  next_xdata_rdata = {`PPOM_P2_PAD, port_two_latch};
      default:            next_xdata_rdata = `PPOM_ZERO_BYTE;
    endcase
  end

  // read data registers, hold between reads
  always @(posedge clk) begin
    if (!reset_n) begin
      sfr_rdata   <= `PPOM_ZERO_BYTE;
      xdata_rdata <= `PPOM_ZERO_BYTE;
    end else begin
      if (sfr_re) begin
        sfr_rdata <= next_sfr_rdata;
      end
      if (xdata_re) begin
        xdata_rdata <= next_xdata_rdata;
      end
    end
  end

  // -----------------------------------------------------------------
  // port zero: clock output, analog, peripheral, gpio
  // -----------------------------------------------------------------
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_zero
      wire clk_pin = clock_output_enable &&
                     (clock_output_pin_select == i);
      // slow clock passes in every power mode; it stops only at source
      assign next_zero_out[i] =
        clk_pin ? slow_clock :
        analog_input_config[i] ? 1'b0 :
        port_zero_function_select[i] ? periph_zero_out[i] :
        port_zero_latch[i];
      assign next_zero_oe[i] =
        clk_pin ? 1'b1 :
        analog_input_config[i] ? 1'b0 :
        port_zero_function_select[i] ? periph_zero_oe[i] :
        port_zero_direction[i];
      assign next_zero_analog[i] = !clk_pin &&
                                   analog_input_config[i];
    end
  endgenerate

  // -----------------------------------------------------------------
  // port one: regulator status, observation, peripheral, gpio
  // -----------------------------------------------------------------
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_one
      wire       reg_pin = regulator_status_output_enable &&
                           (regulator_status_pin_select == i);
      wire       obs_on;
      wire       obs_val;
      if (i < `PPOM_OBS_PINS) begin : g_obs
        wire [1:0] sel = observation_select[2*i+1:2*i];
        assign obs_on  = observation_enable[i];
        assign obs_val = (sel == `PPOM_OBS_SIG_0) ? radio_observe_signal[0] :
                         (sel == `PPOM_OBS_SIG_1) ? radio_observe_signal[1] :
                         (sel == `PPOM_OBS_SIG_2) ? radio_observe_signal[2] :
                         1'b0;
      end else begin : g_no_obs
        assign obs_on  = 1'b0;
        assign obs_val = 1'b0;
      end
      assign next_one_out[i] =
        reg_pin ? regulator_powered :
        obs_on  ? obs_val :
        port_one_function_select[i] ? periph_one_out[i] :
        port_one_latch[i];
      assign next_one_oe[i] =
        (reg_pin || obs_on) ? 1'b1 :
        port_one_function_select[i] ? periph_one_oe[i] :
        port_one_direction[i];
    end
  endgenerate

  // -----------------------------------------------------------------
  // port two: crystal, debug, peripheral, gpio
  // -----------------------------------------------------------------
  generate
    for (i = 0; i < `PPOM_P2_WIDTH; i = i + 1) begin : g_two
      wire xtal = !slow_crystal_select &&
                  ((i == `PPOM_XTAL_BIT_A) ||
                   (i == `PPOM_XTAL_BIT_B));
      wire dbg_d = debug_mode && (i == `PPOM_DEBUG_DATA_BIT);
      wire dbg_c = debug_mode && (i == `PPOM_DEBUG_CLOCK_BIT);
      assign next_two_out[i] =
        xtal  ? 1'b0 :
        dbg_d ? debug_data_out :
        dbg_c ? debug_clock_out :
        port_two_function_select[i] ? periph_two_out[i] :
        port_two_latch[i];
      assign next_two_oe[i] =
        xtal  ? 1'b0 :
        dbg_d ? debug_data_oe :
        dbg_c ? debug_clock_oe :
        port_two_function_select[i] ? periph_two_oe[i] :
        port_two_direction[i];
      assign next_two_analog[i] = xtal;
      assign next_two_pull[i]   = !(xtal || dbg_d || dbg_c);
    end
  endgenerate

  // -----------------------------------------------------------------
  // pad drive registers; all pins released during reset
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      port_zero_out        <= `PPOM_ZERO_BYTE;
      port_zero_oe         <= `PPOM_ZERO_BYTE;
      port_zero_analog     <= `PPOM_ZERO_BYTE;
      port_one_out         <= `PPOM_ZERO_BYTE;
      port_one_oe          <= `PPOM_ZERO_BYTE;
      port_two_out         <= `PPOM_ZERO_FIVE;
      port_two_oe          <= `PPOM_ZERO_FIVE;
      port_two_analog      <= `PPOM_ZERO_FIVE;
      port_two_pull_enable <= `PPOM_PULL_ALLOWED;
    end else begin
      port_zero_out        <= next_zero_out;
      port_zero_oe         <= next_zero_oe;
      port_zero_analog     <= next_zero_analog;
      port_one_out         <= next_one_out;
      port_one_oe          <= next_one_oe;
      port_two_out         <= next_two_out;
      port_two_oe          <= next_two_oe;
      port_two_analog      <= next_two_analog;
      port_two_pull_enable <= next_two_pull;
    end
  end

endmodule // ppom_top

// File: tb/ppom_top_props.sv
// concurrent checks on the port pin override mux ports
`timescale 1ns/1ns
module ppom_top_props (
  input wire        clk,
  input wire        reset_n,
  input wire [7:0]  sfr_addr,
  input wire [7:0]  sfr_wdata,
  input wire        sfr_we,
  input wire        sfr_re,
  input wire [7:0]  sfr_rdata,
  input wire        sfr_bit_we,
  input wire [15:0] xdata_addr,
  input wire        xdata_re,
  input wire [7:0]  xdata_rdata,
  input wire [7:0]  analog_input_config,
  input wire        slow_crystal_select,
  input wire [5:0]  observation_enable,
  input wire [11:0] observation_select,
  input wire        clock_output_enable,
  input wire [2:0]  clock_output_pin_select,
  input wire        regulator_status_output_enable,
  input wire [2:0]  regulator_status_pin_select,
  input wire        debug_mode,
  input wire        debug_data_oe,
  input wire        debug_clock_oe,
  input wire [2:0]  radio_observe_signal,
  input wire        slow_clock,
  input wire        regulator_powered,
  input wire [7:0]  port_zero_out,
  input wire [7:0]  port_zero_oe,
  input wire [7:0]  port_zero_analog,
  input wire [7:0]  port_one_out,
  input wire [7:0]  port_one_oe,
  input wire [4:0]  port_two_oe,
  input wire [4:0]  port_two_analog,
  input wire [4:0]  port_two_pull_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a latch write followed at once by a mirror read
  sequence p1_write_then_read;
    sfr_we && sfr_addr == 8'h90 && !sfr_bit_we
    ##1 xdata_re && xdata_addr == 16'h7090;
  endsequence
  // pad controls follow their claiming source one cycle later
  xtal_pins_a: assert property (!slow_crystal_select |=>
    port_two_analog[4:3] == 2'h3 && port_two_oe[4:3] == 2'h0)
    else $error("crystal pins not released to oscillator");
  debug_pull_a: assert property (debug_mode |=>
    port_two_pull_enable[2:1] == 2'h0) else $error("debug pin pull on");
  debug_drive_a: assert property (debug_mode |=>
    port_two_oe[2:1] == {$past(debug_clock_oe), $past(debug_data_oe)})
    else $error("debug pins not under debug direction");
  clock_out_a: assert property (clock_output_enable |=>
    port_zero_oe[$past(clock_output_pin_select)] &&
    port_zero_out[$past(clock_output_pin_select)] == $past(slow_clock))
    else $error("clock output pin wrong");
  reg_status_a: assert property (regulator_status_output_enable |=>
    port_one_oe[$past(regulator_status_pin_select)] &&
    port_one_out[$past(regulator_status_pin_select)] ==
    $past(regulator_powered)) else $error("regulator status pin wrong");
  // skip the first edge after reset, where pads still hold reset values
  analog_exact_a: assert property ($past(reset_n) |->
    port_zero_analog == $past(analog_input_config &
    ~({7'h00, clock_output_enable} << clock_output_pin_select)))
    else $error("port zero analog wrong");
  obs_pin_a: assert property (observation_enable[0] &&
    !(regulator_status_output_enable &&
    regulator_status_pin_select == 3'h0) |=> port_one_oe[0] &&
    port_one_out[0] == $past(observation_select[1:0] == 2'h3 ? 1'b0 :
    radio_observe_signal[observation_select[1:0]]))
    else $error("observation pin wrong");
  unmapped_read_a: assert property (sfr_re && sfr_addr != 8'h80 &&
    sfr_addr != 8'h90 && sfr_addr != 8'hA0 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  mirror_read_a: assert property (p1_write_then_read |=>
    xdata_rdata == $past(sfr_wdata, 2)) else $error("mirror read wrong");
endmodule // ppom_top_props

bind ppom_top ppom_top_props u_props (.*);

// File: tb/ppom_board_model.sv
// board side of the pads: pin levels from pad drive or external drive
`timescale 1ns/1ns
module ppom_board_model (
  input  wire [7:0] port_zero_out,
  input  wire [7:0] port_zero_oe,
  input  wire [7:0] port_one_out,
  input  wire [7:0] port_one_oe,
  input  wire [4:0] port_two_out,
  input  wire [4:0] port_two_oe,
  input  wire [7:0] ext_zero,
  input  wire [7:0] ext_one,
  input  wire [4:0] ext_two,
  output wire [7:0] port_zero_in,
  output wire [7:0] port_one_in,
  output wire [4:0] port_two_in
);
  // a driven pad wins; an undriven pin shows the external source
  assign port_zero_in = (port_zero_out & port_zero_oe) | (ext_zero & ~port_zero_oe);
  assign port_one_in  = (port_one_out & port_one_oe) | (ext_one & ~port_one_oe);
  assign port_two_in  = (port_two_out & port_two_oe) | (ext_two & ~port_two_oe);
endmodule // ppom_board_model

// File: tb/tb_port_pin_override_mux.sv
// self-checking bench for the port pin override mux
`timescale 1ns/1ns
module tb_port_pin_override_mux;
  reg         clk, reset_n, sfr_we, sfr_re, sfr_bit_wdata, sfr_bit_we;
  reg         xdata_re, slow_crystal_select, clock_output_enable, debug_mode;
  reg         regulator_status_output_enable, debug_data_out, debug_data_oe;
  reg         debug_clock_out, debug_clock_oe, slow_clock, regulator_powered;
  reg  [7:0]  sfr_addr, sfr_wdata, sfr_bit_addr, analog_input_config;
  reg  [7:0]  port_zero_function_select, port_one_function_select;
  reg  [7:0]  port_zero_direction, port_one_direction, ext_zero, ext_one;
  reg  [7:0]  periph_zero_out, periph_zero_oe, periph_one_out, periph_one_oe;
  reg  [4:0]  port_two_function_select, port_two_direction, ext_two;
  reg  [4:0]  periph_two_out, periph_two_oe;
  reg  [15:0] xdata_addr;
  reg  [5:0]  observation_enable;
  reg  [11:0] observation_select;
  reg  [2:0]  clock_output_pin_select, regulator_status_pin_select;
  reg  [2:0]  radio_observe_signal;
  wire [7:0]  sfr_rdata, xdata_rdata, port_zero_level, port_one_level;
  wire [7:0]  port_zero_in, port_zero_out, port_zero_oe, port_zero_analog;
  wire [7:0]  port_one_in, port_one_out, port_one_oe;
  wire [4:0]  port_two_level, port_two_in, port_two_out, port_two_oe;
  wire [4:0]  port_two_analog, port_two_pull_enable;
  integer     fail_count = 0;
  integer     n_tests = 0;
  integer     s;

  ppom_top dut_u (.*);
  ppom_board_model board_u (.*);

  // free-running clock
  always #5 clk = ~clk;

  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // bus tasks start and end on a falling edge
  task wr(input [7:0] a, input [7:0] d);
    begin
      sfr_addr = a;
      sfr_wdata = d;
      sfr_we = 1'b1;
      @(negedge clk);
      sfr_we = 1'b0;
    end
  endtask
  task bw(input [7:0] a, input d);
    begin
      sfr_bit_addr = a;
      sfr_bit_wdata = d;
      sfr_bit_we = 1'b1;
      @(negedge clk);
      sfr_bit_we = 1'b0;
      @(negedge clk); // idle edge between back-to-back strobes
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      sfr_addr = a;
      sfr_re = 1'b1;
      @(negedge clk);
      sfr_re = 1'b0;
      chk("sfr read", e, sfr_rdata);
    end
  endtask
  task xr(input [15:0] a, input [7:0] e);
    begin
      xdata_addr = a;
      xdata_re = 1'b1;
      @(negedge clk);
      xdata_re = 1'b0;
      chk("xdata read", e, xdata_rdata);
      @(negedge clk); // idle edge between back-to-back strobes
    end
  endtask
  task settle;
    repeat (2) @(negedge clk);
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // watchdog well beyond the 65 or so cycles of the sequence
  initial begin
    #200000;
    fail_count = fail_count + 1;
    summarize;
  end

  // main sequence
  initial begin
    {clk, reset_n, sfr_we, sfr_re, sfr_bit_wdata, sfr_bit_we, xdata_re,
     clock_output_enable, debug_mode, regulator_status_output_enable,
     debug_data_out, debug_data_oe, debug_clock_out, debug_clock_oe,
     slow_clock, regulator_powered, sfr_addr, sfr_wdata, sfr_bit_addr,
     analog_input_config, port_zero_function_select, ext_zero, ext_one,
     port_one_function_select, periph_zero_out, periph_zero_oe,
     periph_one_out, periph_one_oe, port_two_function_select, ext_two,
     periph_two_out, periph_two_oe, xdata_addr, observation_enable,
     observation_select, clock_output_pin_select, radio_observe_signal,
     regulator_status_pin_select} = 0;
    slow_crystal_select = 1'b1;
    {port_zero_direction, port_one_direction} = 16'hFFFF;
    port_two_direction = 5'h1F;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    xr(16'h7080, 8'hFF);
    xr(16'h7090, 8'hFF);
    xr(16'h70A0, 8'h1F);
    chk("p1 level", 8'hFF, port_one_level);
    chk("p2 level", 8'h1F, port_two_level);
    rd(8'h80, 8'hFF);
    wr(8'h90, 8'h0F);
    xr(16'h7090, 8'h0F);
    wr(8'hA0, 8'hFF);
    rd(8'hA0, 8'h1F);
    bw(8'h81, 1'b0);
    bw(8'hA5, 1'b1);
    rd(8'h80, 8'hFD);
    xr(16'h70A0, 8'h1F);
    rd(8'hB0, 8'h00);
    xr(16'h7000, 8'h00);
    port_zero_direction = 8'h00;
    ext_zero = 8'hA5;
    repeat (6) @(negedge clk);
    rd(8'h80, 8'hA5);
    port_zero_direction = 8'hFF;
    port_one_direction = 8'h70;
    port_one_function_select = 8'h80;
    periph_one_oe = 8'h80;
    periph_one_out = 8'h80;
    settle;
    chk("p1 oe", 8'hF0, port_one_oe);
    chk("p1 out", 8'h80, port_one_out & 8'hF0);
    port_zero_function_select = 8'hFF;
    periph_zero_oe = 8'hFF;
    periph_zero_out = 8'hFF;
    analog_input_config = 8'h0F;
    settle;
    chk("p0 analog", 8'h0F, port_zero_analog);
    chk("p0 oe", 8'hF0, port_zero_oe);
    clock_output_enable = 1'b1;
    clock_output_pin_select = 3'h2;
    slow_clock = 1'b1;
    settle;
    chk("clk pin oe", 8'hF4, port_zero_oe);
    chk("clk pin", 8'h04, port_zero_out & 8'h04);
    chk("clk pin analog", 8'h0B, port_zero_analog);
    slow_clock = 1'b0;
    settle;
    chk("clk pin low", 8'h00, port_zero_out & 8'h04);
    periph_one_out = 8'h00;
    regulator_status_output_enable = 1'b1;
    regulator_status_pin_select = 3'h7;
    for (s = 1; s >= 0; s = s - 1) begin
      regulator_powered = s[0];
      settle;
      chk("reg pin", {s[0], 7'h00}, port_one_out & 8'h80);
    end
    observation_enable = 6'h01;
    radio_observe_signal = 3'h5;
    for (s = 0; s < 4; s = s + 1) begin
      observation_select = s[11:0];
      settle;
      chk("obs oe", 8'h01, port_one_oe & 8'h01);
      chk("obs pin", (s == 0 || s == 2), port_one_out & 8'h01);
    end
    debug_mode = 1'b1;
    debug_data_oe = 1'b1;
    debug_data_out = 1'b1;
    debug_clock_oe = 1'b1;
    debug_clock_out = 1'b1;
    settle;
    chk("dbg pull", 8'h00, port_two_pull_enable & 5'h06);
    chk("dbg oe", 8'h06, port_two_oe & 5'h06);
    chk("dbg out", 8'h06, port_two_out & 5'h06);
    slow_crystal_select = 1'b0;
    settle;
    chk("xtal analog", 8'h18, port_two_analog & 5'h18);
    chk("xtal oe", 8'h00, port_two_oe & 5'h18);
    // second reset in mid-run; port zero and one latches must return to all ones
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    xr(16'h7080, 8'hFF);
    xr(16'h7090, 8'hFF);
    summarize;
  end
endmodule // tb_port_pin_override_mux
